// ### dlh_pkg.sv
// Constants for the second data-link control block: register map,
// field positions, reset values, abort and check sequence figures.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package dlh_pkg;

  // Register byte offsets
  localparam logic [7:0] DLH_OFS_PERF = 8'h00;
  localparam logic [7:0] DLH_OFS_CTRL = 8'h04;
  localparam logic [7:0] DLH_OFS_STAT = 8'h08;

  // Report control fields
  localparam int DLH_PERF_U2  = 4;
  localparam int DLH_PERF_RSV = 0;
  localparam int DLH_RSV_W    = 4;

  // Data link control two fields
  localparam int DLH_CTL_LEG  = 7;
  localparam int DLH_CTL_AAD  = 6;
  localparam int DLH_CTL_RCD  = 5;
  localparam int DLH_CTL_DUP  = 4;
  localparam int DLH_CTL_FAB  = 3;
  localparam int DLH_CTL_SEL  = 0;

  // Status fields
  localparam int DLH_ST_AUTO  = 0;
  localparam int DLH_ST_LEG   = 1;
  localparam int DLH_ST_BAD   = 2;
  localparam int DLH_ST_DUP   = 3;

  // Reset values
  localparam logic [7:0] DLH_PERF_RST = 8'h00;
  localparam logic [7:0] DLH_CTRL_RST = 8'h00;

  // Writable masks
  localparam logic [7:0] DLH_PERF_MSK = 8'hFF;
  localparam logic [7:0] DLH_CTRL_MSK = 8'hFF;

  // Automatic abort: one zero then seven ones
  localparam int DLH_ABORT_ONES = 7;
  localparam logic [3:0] DLH_ABORT_LEN = 4'(DLH_ABORT_ONES + 1);

  // Frame check sequence, reflected CCITT polynomial
  localparam logic [15:0] DLH_CRC_POLY = 16'h8408;
  localparam logic [15:0] DLH_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] DLH_CRC_GOOD = 16'hF0B8;

  // Framing formats reported by the framer
  typedef enum logic [1:0] {
    DLH_FMT_SF,
    DLH_FMT_ESF,
    DLH_FMT_LEGACY,
    DLH_FMT_OTHER
  } dlh_fmt_e;

endpackage : dlh_pkg

// ### dlh_fcs_check.sv
// Serial frame check sequence engine for received link frames.
// Assumes bits arrive least significant first, one per valid strobe,
// with a start strobe from the flag and stuffing logic.
`timescale 1ns/1ps
module dlh_fcs_check
  import dlh_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic        bit_vld_i,
  input  wire logic        bit_i,
  output logic [15:0]      crc_o,
  output logic [15:0]      len_o,
  output logic             good_o
);

  logic [15:0] crc_r;
  logic [15:0] len_r;
  logic        fb;

  assign fb = crc_r[0] ^ bit_i;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_r <= DLH_CRC_INIT;
    end else if (start_i) begin
      crc_r <= DLH_CRC_INIT;
    end else if (bit_vld_i) begin
      crc_r <= (crc_r >> 1) ^ (fb ? DLH_CRC_POLY : 16'h0000);
    end
  end

  // Length makes two frames with equal check words still differ
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      len_r <= 16'h0000;
    end else if (start_i) begin
      len_r <= 16'h0000;
    end else if (bit_vld_i) begin
      len_r <= len_r + 16'h0001;
    end
  end

  assign crc_o  = crc_r;
  assign len_o  = len_r;
  assign good_o = (crc_r == DLH_CRC_GOOD);

endmodule : dlh_fcs_check

// ### dlh_control.sv
// Second data-link controller control path: report bits, legacy
// carrier link selection, automatic and forced abort, receive check
// and repeat-message discard, behind a classic Wishbone slave.
// Assumes the framer gives slot strobes and format on clock_i.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// R1: Spare bit two goes into every report
// R2: Reserved four bits go into every report
// R3: Legacy enable picks legacy link or SF bits
// R4: Legacy enable honoured only in legacy/ESF framing
// R5: Auto abort: zero then seven ones on switch
// R6: Auto abort disable bit suppresses that sequence
// R7: Check disable bit skips receive FCS check
// R8: Discard enable drops repeats of held message
// R9: Forced abort bit sends continuous ones
// R10: Select bit: 0 bit-oriented, 1 message-oriented
// R11: Abort bits only in data-link positions
module dlh_control
  import dlh_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Framer side
  input  wire logic [1:0]  fmt_i,
  input  wire logic        dl_slot_i,
  input  wire logic        fbit_slot_i,
  input  wire logic        pass_bit_i,
  input  wire logic        sf_fbit_i,
  input  wire logic        leg_fbit_i,
  output logic             tx_line_o,
  // Transmit link controller side
  input  wire logic        tx_msg_bit_i,
  input  wire logic        tx_mos_busy_i,
  output logic             tx_mos_o,
  output logic             spare_bit_o,
  output logic [3:0]       resv_bits_o,
  output logic             legacy_link_o,
  // Receive link controller side
  input  wire logic        rx_start_i,
  input  wire logic        rx_bit_vld_i,
  input  wire logic        rx_bit_i,
  input  wire logic        rx_end_i,
  output logic             rx_accept_o,
  output logic             rx_drop_o
);

  typedef enum logic [1:0] {
    DLH_AB_IDLE,
    DLH_AB_ZERO,
    DLH_AB_ONES
  } dlh_ab_e;

  logic [7:0]  perf_r;
  logic [7:0]  ctrl_r;
  logic        wb_ack_r;
  logic [31:0] wb_dat_r;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  ctrl_nxt;
  logic        arm_nxt;
  logic        arm_r;
  dlh_ab_e     ab_r;
  logic [3:0]  ab_cnt_r;
  logic        leg_eff;
  logic        tx_line_r;
  logic        tx_nxt;
  logic [15:0] tail_r;
  logic [15:0] len_w;
  logic        good_w;
  logic [15:0] held_crc_r;
  logic [15:0] held_len_r;
  logic        held_vld_r;
  logic        acc_r;
  logic        drop_r;
  logic        last_bad_r;
  logic        last_dup_r;
  logic        is_bad;
  logic        is_dup;
  logic        mos_r;
  logic        spare_r;
  logic [3:0]  resv_r;
  logic        leg_r;

  // Byte lane 0 carries the eight-bit registers
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] msk);
    merge_byte = wb_sel_i[0] ? ((old & ~msk) | (wb_dat_i[7:0] & msk)) : old;
  endfunction : merge_byte

  // Write strobe for one register offset
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_hit && (wb_adr_i == ofs);
  endfunction : wr_at

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_r;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_r;

  // ---------------- Wishbone slave ----------------

  // One wait state; ack dropped in the cycle after it was given
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      perf_r <= DLH_PERF_RST;
    end else if (wr_at(DLH_OFS_PERF)) begin
      perf_r <= merge_byte(perf_r, DLH_PERF_MSK);
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_at(DLH_OFS_CTRL)) begin
      ctrl_nxt = merge_byte(ctrl_r, DLH_CTRL_MSK);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= DLH_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Unmapped addresses read zero and still get an ack
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (rd_hit) begin
      unique case (wb_adr_i)
        DLH_OFS_PERF: wb_dat_r <= {24'h00_0000, perf_r};
        DLH_OFS_CTRL: wb_dat_r <= {24'h00_0000, ctrl_r};
        DLH_OFS_STAT: begin
          wb_dat_r <= 32'h0000_0000;
          wb_dat_r[DLH_ST_AUTO] <= (ab_r != DLH_AB_IDLE);
          wb_dat_r[DLH_ST_LEG]  <= leg_eff;
          wb_dat_r[DLH_ST_BAD]  <= last_bad_r;
          wb_dat_r[DLH_ST_DUP]  <= last_dup_r;
        end
        default: wb_dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- Report and mode outputs ----------------

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spare_r <= 1'b0;
      resv_r  <= 4'h0;
    end else begin
      spare_r <= perf_r[DLH_PERF_U2]; // R1
      resv_r  <= perf_r[DLH_PERF_RSV +: DLH_RSV_W]; // R2
    end
  end

  // Plain level: software rewrites 0 for each bit-oriented send
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mos_r <= 1'b0;
    end else begin
      mos_r <= ctrl_r[DLH_CTL_SEL]; // R10
    end
  end

  // Ignored outside legacy and ESF framing
  assign leg_eff = ctrl_r[DLH_CTL_LEG] &&
                   (fmt_i == DLH_FMT_ESF || fmt_i == DLH_FMT_LEGACY); // R4

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      leg_r <= 1'b0;
    end else begin
      leg_r <= leg_eff; // R3
    end
  end

  // ---------------- Automatic abort ----------------

  // A write that drops the select bit mid-message is the abrupt switch
  assign arm_nxt = ctrl_r[DLH_CTL_SEL] && !ctrl_nxt[DLH_CTL_SEL] &&
                   tx_mos_busy_i && !ctrl_r[DLH_CTL_AAD]; // R5 R6

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arm_r <= 1'b0;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // Sequence advances only on data-link slots so payload is untouched
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ab_r     <= DLH_AB_IDLE;
      ab_cnt_r <= 4'h0;
    end else begin
      unique case (ab_r)
        DLH_AB_IDLE: begin
          if (arm_r) begin
            ab_r     <= DLH_AB_ZERO; // R5
            ab_cnt_r <= DLH_ABORT_LEN;
          end
        end
        DLH_AB_ZERO: begin
          if (dl_slot_i) begin
            ab_r     <= DLH_AB_ONES;
            ab_cnt_r <= ab_cnt_r - 4'h1;
          end
        end
        DLH_AB_ONES: begin
          if (dl_slot_i) begin
            ab_cnt_r <= ab_cnt_r - 4'h1;
            if (ab_cnt_r == 4'h1) begin
              ab_r <= DLH_AB_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------- Transmit line mux ----------------

  // Forced abort outranks the automatic one and the message stream
  always_comb begin
    tx_nxt = pass_bit_i;
    if (dl_slot_i) begin // R11
      if (ctrl_r[DLH_CTL_FAB]) begin
        tx_nxt = 1'b1; // R9
      end else if (ab_r == DLH_AB_ZERO) begin
        tx_nxt = 1'b0; // R5
      end else if (ab_r == DLH_AB_ONES) begin
        tx_nxt = 1'b1; // R5
      end else begin
        tx_nxt = tx_msg_bit_i;
      end
    end else if (fbit_slot_i) begin
      tx_nxt = leg_eff ? leg_fbit_i : sf_fbit_i; // R3
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_line_r <= 1'b1;
    end else begin
      tx_line_r <= tx_nxt;
    end
  end

  // ---------------- Receive check and discard ----------------

  // Engine residue gives only the good or bad verdict
  dlh_fcs_check u_fcs (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .start_i   (rx_start_i),
    .bit_vld_i (rx_bit_vld_i),
    .bit_i     (rx_bit_i),
    .crc_o     (),
    .len_o     (len_w),
    .good_o    (good_w)
  );

  assign is_bad = !ctrl_r[DLH_CTL_RCD] && !good_w; // R7

  // Every good frame leaves the same residue, so the sent check word
  // itself tells messages apart; cleared at start so a short frame
  // cannot match bits of the one before
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tail_r <= 16'h0000;
    end else if (rx_start_i) begin
      tail_r <= 16'h0000;
    end else if (rx_bit_vld_i) begin
      tail_r <= {rx_bit_i, tail_r[15:1]};
    end
  end

  // Repeat match by check word and length, not a full byte compare
  assign is_dup = ctrl_r[DLH_CTL_DUP] && held_vld_r &&
                  held_crc_r == tail_r && held_len_r == len_w; // R8

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r  <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      acc_r  <= rx_end_i && !is_bad && !is_dup;
      drop_r <= rx_end_i && (is_bad || is_dup);
    end
  end

  // The held signature follows whatever is now in the receive buffer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held_vld_r <= 1'b0;
      held_crc_r <= 16'h0000;
      held_len_r <= 16'h0000;
    end else if (rx_end_i && !is_bad && !is_dup) begin
      held_vld_r <= 1'b1;
      held_crc_r <= tail_r;
      held_len_r <= len_w;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_bad_r <= 1'b0;
      last_dup_r <= 1'b0;
    end else if (rx_end_i) begin
      last_bad_r <= is_bad;
      last_dup_r <= is_dup && !is_bad;
    end
  end

  assign wb_ack_o      = wb_ack_r;
  assign wb_dat_o      = wb_dat_r;
  assign tx_line_o     = tx_line_r;
  assign tx_mos_o      = mos_r;
  assign spare_bit_o   = spare_r;
  assign resv_bits_o   = resv_r;
  assign legacy_link_o = leg_r;
  assign rx_accept_o   = acc_r;
  assign rx_drop_o     = drop_r;

endmodule : dlh_control

// ### dlh_checker.sv
// Port checker for the data-link control block.
// Assumes it is bound to dlh_control and sees one clock domain.
`timescale 1ns/1ps
module dlh_checker
  import dlh_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  fmt_i,
  input wire logic        dl_slot_i,
  input wire logic        fbit_slot_i,
  input wire logic        pass_bit_i,
  input wire logic        sf_fbit_i,
  input wire logic        leg_fbit_i,
  input wire logic        tx_line_o,
  input wire logic        tx_mos_o,
  input wire logic        spare_bit_o,
  input wire logic [3:0]  resv_bits_o,
  input wire logic        legacy_link_o,
  input wire logic        rx_end_i,
  input wire logic        rx_accept_o,
  input wire logic        rx_drop_o
);
  logic wr_perf;
  logic wr_ctrl;
  assign wr_perf = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DLH_OFS_PERF;
  assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DLH_OFS_CTRL;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_spare; wr_perf |-> ##2 spare_bit_o == $past(wb_dat_i[DLH_PERF_U2], 2); endproperty
  a_spare: assert property (p_spare) else $error("spare bit wrong");
  property p_resv; wr_perf |-> ##2 resv_bits_o == $past(wb_dat_i[3:0], 2); endproperty
  a_resv: assert property (p_resv) else $error("reserved bits wrong");
  property p_sel; wr_ctrl |-> ##2 tx_mos_o == $past(wb_dat_i[DLH_CTL_SEL], 2); endproperty
  a_sel: assert property (p_sel) else $error("type select wrong");
  // Reset release edge may still hold the idle line level
  property p_pass;
    $past(nrst_i) && !dl_slot_i && !fbit_slot_i |=> tx_line_o == $past(pass_bit_i);
  endproperty
  a_pass: assert property (p_pass) else $error("payload bit altered");
  property p_fbit;
    $past(nrst_i) && fbit_slot_i && !dl_slot_i
      |=> tx_line_o == (legacy_link_o ? $past(leg_fbit_i) : $past(sf_fbit_i));
  endproperty
  a_fbit: assert property (p_fbit) else $error("framing bit wrong");
  property p_rx; rx_end_i |=> rx_accept_o != rx_drop_o; endproperty
  a_rx: assert property (p_rx) else $error("frame verdict missing");
  c_wr: cover property (wr_ctrl);
  c_drop: cover property (rx_drop_o);
  c_leg: cover property (legacy_link_o);
endmodule : dlh_checker

// ### dlh_far_model.sv
// Remote end model: sends received link frames, data LSB first.
// Assumes the bench calls send for one frame at a time.
`timescale 1ns/1ps
module dlh_far_model
  import dlh_pkg::*;
(
  input  wire logic clock_i,
  output logic      rx_start_o = 1'b0,
  output logic      rx_vld_o = 1'b0,
  output logic      rx_bit_o = 1'b0,
  output logic      rx_end_o = 1'b0
);
  task automatic send(input logic [7:0] d, input logic bad);
    logic [15:0] c;
    logic [23:0] f;
    c = DLH_CRC_INIT;
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? DLH_CRC_POLY : 16'h0000);
    f = {~c ^ {15'h0000, bad}, d};
    @(posedge clock_i);
    rx_start_o <= 1'b1;
    @(posedge clock_i);
    rx_start_o <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      {rx_vld_o, rx_bit_o} <= {1'b1, f[i]};
      @(posedge clock_i);
    end
    // Idle line shows the inverse so stale data never matches
    {rx_vld_o, rx_bit_o, rx_end_o} <= {1'b0, ~f[23], 1'b1};
    @(posedge clock_i);
    rx_end_o <= 1'b0;
  endtask : send
endmodule : dlh_far_model

// ### tb_data_link_hdlc2_control.sv
// Self-checking bench: registers, line bits, aborts, receive verdicts.
// Assumes one bus answer per request and a remote end model.
`timescale 1ns/1ps
module tb_data_link_hdlc2_control;
  import dlh_pkg::*;
  localparam logic [7:0] RXC [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h20};
  localparam logic [7:0] RXD [6] = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h3C, 8'h3C};
  localparam logic [5:0] RXB = 6'b100100;
  localparam logic [5:0] RXA = 6'b110011;
  logic clock_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0;
  logic dl = 1'b0, fb = 1'b0, pb = 1'b0, sf = 1'b0, lg = 1'b0, msg = 1'b0;
  logic [1:0] fmt = 2'b00;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000, rdat;
  logic ack, tx, message_oriented_signaling, spare, leg, acc, drp, rs, rv, rb, re;
  logic [3:0] resv;
  int err_count = 0, tests_run = 0;
  always #25 clock_i = ~clock_i;
  dlh_control u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .fmt_i(fmt), .dl_slot_i(dl), .fbit_slot_i(fb), .pass_bit_i(pb),
    .sf_fbit_i(sf), .leg_fbit_i(lg), .tx_line_o(tx), .tx_msg_bit_i(msg),
    .tx_mos_busy_i(busy), .tx_mos_o(message_oriented_signaling), .spare_bit_o(spare), .resv_bits_o(resv),
    .legacy_link_o(leg), .rx_start_i(rs), .rx_bit_vld_i(rv), .rx_bit_i(rb),
    .rx_end_i(re), .rx_accept_o(acc), .rx_drop_o(drp));
  dlh_far_model u_far (.clock_i(clock_i), .rx_start_o(rs), .rx_vld_o(rv), .rx_bit_o(rb),
    .rx_end_o(re));
  task automatic close_out;
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic leg_exp(input logic en, input logic [1:0] f);
    leg_exp = en && (f == 2'(DLH_FMT_ESF) || f == 2'(DLH_FMT_LEGACY));
  endfunction : leg_exp
  function automatic logic [31:0] stat_exp(input logic bad, input logic dup);
    stat_exp = 32'h00000000;
    stat_exp[DLH_ST_BAD] = bad;
    stat_exp[DLH_ST_DUP] = dup;
  endfunction : stat_exp
  // Waits for the answer however long; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clock_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h000000, d};
    do begin
      @(posedge clock_i);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // Extra cycles let registered mode outputs settle
  task automatic line(input logic [7:0] v, output logic q);
    @(posedge clock_i);
    {fmt, dl, fb, pb, sf, lg, msg} <= v;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    q = tx;
  endtask : line
  initial begin
    #500000;
    err_count++;
    close_out();
  end
  initial begin
    logic [31:0] q;
    logic [7:0]  v;
    logic [1:0]  r;
    logic        t;
    logic        e;
    logic        b;
    int          ones;
    q = $urandom(32'hD8C1);
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    wb(1'b0, DLH_OFS_PERF, 8'h00, q);
    chk("perf_rst", q, 32'(DLH_PERF_RST));
    wb(1'b1, 8'h0C, 8'hFF, q);
    wb(1'b0, 8'h0C, 8'h00, q);
    chk("unmapped", q, 32'h00000000);
    repeat (4) begin
      v = 8'($urandom);
      wb(1'b1, DLH_OFS_PERF, v, q);
      wb(1'b0, DLH_OFS_PERF, 8'h00, q);
      chk("perf_rd", q, {24'h000000, v});
      chk("spare", 32'(spare), 32'(v[4]));
      chk("resv", 32'(resv), 32'(v[3:0]));
    end
    sel <= 4'hE;
    wb(1'b1, DLH_OFS_PERF, ~v, q);
    sel <= 4'hF;
    wb(1'b0, DLH_OFS_PERF, 8'h00, q);
    chk("sel_off", q, {24'h000000, v});
    for (int i = 0; i < 8; i++) begin
      r = 2'($urandom);
      e = leg_exp(i[2], i[1:0]);
      wb(1'b1, DLH_OFS_CTRL, {i[2], 7'h00}, q);
      line({i[1:0], 3'b010, r, 1'b0}, t);
      chk("leg_eff", 32'(leg), 32'(e));
      chk("fbit", 32'(t), 32'(e ? r[0] : r[1]));
      line({2'b00, 2'b00, r[0], 3'b000}, t);
      chk("pass", 32'(t), 32'(r[0]));
    end
    wb(1'b1, DLH_OFS_CTRL, 8'h08, q);
    line({2'b00, 1'b1, 5'b00000}, t);
    chk("forced", 32'(t), 32'h00000001);
    @(posedge clock_i);
    busy <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, DLH_OFS_CTRL, {1'b0, k[0], 6'h01}, q);
      @(negedge clock_i);
      chk("mos_set", 32'(message_oriented_signaling), 32'h00000001);
      wb(1'b1, DLH_OFS_CTRL, {1'b0, k[0], 6'h00}, q);
      ones = 0;
      repeat (16) begin
        @(negedge clock_i);
        ones += int'(tx === 1'b1);
      end
      chk("abort_ones", ones, k ? 0 : DLH_ABORT_ONES);
      chk("mos_clr", 32'(message_oriented_signaling), 32'h00000000);
    end
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, DLH_OFS_CTRL, RXC[i], q);
      u_far.send(RXD[i], RXB[i]);
      @(negedge clock_i);
      chk("accept", 32'(acc), 32'(RXA[i]));
      chk("drop", 32'(drp), 32'(!RXA[i]));
      b = RXB[i] && !RXC[i][DLH_CTL_RCD];
      wb(1'b0, DLH_OFS_STAT, 8'h00, q);
      chk("stat", q, stat_exp(b, !RXA[i] && !b));
    end
    close_out();
  end
endmodule : tb_data_link_hdlc2_control
bind dlh_control dlh_checker u_chk (.*);
